// [design/ccsr_cfg.svh]
// Offsets, field positions, reset values and masks of the core control register set
`ifndef CCSR_CFG_SVH
`define CCSR_CFG_SVH

`define CCSR_ADDR_W 6
`define CCSR_ADDR_STATE 6'h00
`define CCSR_ADDR_SAVED_STATE 6'h04
`define CCSR_ADDR_SAVED_FETCH 6'h08
`define CCSR_ADDR_GLOBAL_BASE 6'h0c
`define CCSR_ADDR_VECTOR_BASE 6'h10
`define CCSR_ADDR_SAVED_STACK 6'h14
`define CCSR_ADDR_BREAK_BASE 6'h18
`define CCSR_ADDR_MAC_HIGH 6'h1c
`define CCSR_ADDR_MAC_LOW 6'h20
`define CCSR_ADDR_RETURN 6'h24
`define CCSR_ADDR_IPTR 6'h28
`define CCSR_ADDR_FLOAT 6'h2c
`define CCSR_ADDR_OP_CONFIG 6'h30
`define CCSR_ADDR_BREAK_CONFIG 6'h34

`define CCSR_SR_MD 30
`define CCSR_SR_RB 29
`define CCSR_SR_BL 28
`define CCSR_SR_M 9
`define CCSR_SR_Q 8
`define CCSR_SR_MASK_HI 7
`define CCSR_SR_MASK_LO 4
`define CCSR_SR_S 1
`define CCSR_SR_T 0
`define CCSR_SR_RESET 32'h700000f0
`define CCSR_SR_WMASK 32'h700083f3

`define CCSR_FP_FR 21
`define CCSR_FP_SZ 20
`define CCSR_FP_PR 19
`define CCSR_FP_DN 18
`define CCSR_FP_RM_HI 1
`define CCSR_FP_RM_LO 0
`define CCSR_FP_RESET 32'h00040001
`define CCSR_FP_WMASK 32'h003fffff

`define CCSR_OPCFG_LEVEL_UPDATE 0
`define CCSR_BRKCFG_REDIRECT 0
`define CCSR_IPTR_RESET 32'ha0000000
`define CCSR_WORD_ZERO 32'h00000000

`endif

// [design/ccsr_pkg.sv]
// Types shared by the core control register set
package ccsr_pkg;
    typedef logic [31:0] ccsr_word_type;
    typedef enum logic [1:0] {
        CCSR_ENTRY_NONE = 2'b00,
        CCSR_ENTRY_EXC = 2'b01,
        CCSR_ENTRY_IRQ = 2'b10
    } ccsr_entry_type;
endpackage

// [design/ccsr_trap_if.sv]
// Signals between the register set and its interrupt gate and vector selector
`timescale 1ns/1ps
`default_nettype none
interface ccsr_trap_if;
    logic [3:0] mask;
    logic hold;
    logic req;
    logic [3:0] level;
    logic accept;
    logic redirect;
    logic brk;
    logic [31:0] vbase;
    logic [31:0] dbase;
    logic [15:0] offset;
    logic [31:0] target;
    modport gate (input mask, hold, req, level, output accept);
    modport vsel (input redirect, brk, vbase, dbase, offset, output target);
    modport core (output mask, hold, req, level, redirect, brk, vbase, dbase, offset,
                  input accept, target);
endinterface
`default_nettype wire

// [design/ccsr_irq_gate.sv]
// Interrupt acceptance against the level mask and the block bit
`timescale 1ns/1ps
`default_nettype none
module ccsr_irq_gate
    import ccsr_pkg::*;
(
    ccsr_trap_if.gate trap // Mask, block bit, request and acceptance
);
    // Equal priority is refused as well, only a strictly higher level passes
    assign trap.accept = trap.req && !trap.hold && (trap.level > trap.mask); // RQ1 RQ20
endmodule
`default_nettype wire

// [design/ccsr_vec_sel.sv]
// Branch target selection on exception entry
`timescale 1ns/1ps
`default_nettype none
module ccsr_vec_sel
    import ccsr_pkg::*;
(
    ccsr_trap_if.vsel trap // Bases, break flag and computed target
);
    // A user break with redirect goes straight to the handler base, no offset added
    assign trap.target = (trap.brk && trap.redirect) ? trap.dbase // RQ11
                       : trap.vbase + {16'h0000, trap.offset}; // RQ9
endmodule
`default_nettype wire

// [design/ccsr_regs.sv]
// Core control and system register set with exception entry
// Notes on behaviour
// RQ1 - Four-bit level mask at state bits 7..4, resets all ones; equal or lower refused.
// RQ2 - Operating config bit chooses whether an accepted interrupt rewrites the mask.
// RQ3 - State bit 1 is read/write saturation control for multiply-accumulate, resets 0.
// RQ4 - State bit 0 is read/write condition bit, resets 0, set by instructions.
// RQ5 - Quotient bit is read and updated by divide-initialise and one-step divide.
// RQ6 - Every exception or interrupt copies the whole state word into saved state.
// RQ7 - Every exception or interrupt saves the faulting instruction address.
// RQ8 - Global base register is the base for displacement and index addressing.
// RQ9 - Vector base resets zero and is the base of the trap branch target.
// RQ10 - Every exception or interrupt copies general register 15; privileged access only.
// RQ11 - With redirect enable at 1, user break branches to the debug base instead.
// RQ12 - Multiply-accumulate pair supplies addend and takes multiply results.
// RQ13 - Subroutine call stores return address; return jumps to that value.
// RQ14 - Instruction pointer holds current address and resets to a0000000.
// RQ15 - Float bit 21 swaps the front and extended register banks.
// RQ16 - Float bit 20 selects 32-bit or 64-bit pair moves.
// RQ17 - Float bit 19 selects single or double precision.
// RQ18 - Float bit 18 resets to 1 and flushes subnormal operands to zero.
// RQ19 - Float bits 31..22 are read-only zero.
// RQ20 - Reset, exception or interrupt sets the block bit, which masks interrupts.
// RQ21 - State bit 30 selects privileged mode; every trap forces it to 1.
// RQ22 - Float rounding field resets to 01; 00 nearest, 01 toward zero.
// RQ23 - Saved and base registers are refused to user-mode accesses; the global base register at 0c is not refused.
`timescale 1ns/1ps
`default_nettype none
`include "ccsr_cfg.svh"
module ccsr_regs
    import ccsr_pkg::*;
(
    input wire logic clk, // Core clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic [`CCSR_ADDR_W-1:0] bus_addr, // Register byte address
    input wire logic [31:0] bus_wdata, // Write data
    input wire logic bus_wr, // Write strobe
    input wire logic bus_rd, // Read strobe
    output logic [31:0] bus_rdata, // Read data, cycle after the strobe
    output logic bus_fault, // Privileged access refused, pulse
    input wire logic irq_req, // Interrupt request
    input wire logic [3:0] irq_level, // Interrupt priority level
    output logic irq_accept, // Interrupt taken this cycle
    input wire logic exc_req, // Exception entry request
    input wire logic exc_user_break, // Exception is a user break
    input wire logic [15:0] exc_offset, // Vector offset of the event
    input wire logic [31:0] exc_addr, // Address of the interrupted instruction
    input wire logic [31:0] exc_r15, // General register 15 at entry
    output logic trap_taken, // Entry done, pulse
    output logic [31:0] trap_target, // Branch target of last entry
    input wire logic pc_load, // Load instruction pointer
    input wire logic [31:0] pc_value, // New instruction pointer
    input wire logic call_take, // Subroutine call
    input wire logic [31:0] call_return, // Return address of the call
    input wire logic [31:0] call_target, // Call destination
    input wire logic ret_take, // Subroutine return
    input wire logic mac_we, // Multiply result write
    input wire logic [31:0] mac_hi_in, // Result high word
    input wire logic [31:0] mac_lo_in, // Result low word
    input wire logic t_we, // Condition bit write
    input wire logic t_in, // Condition bit value
    input wire logic div_we, // Divide step write of quotient and divisor sign
    input wire logic q_in, // Quotient bit value
    input wire logic m_in, // Divisor sign bit value
    output logic [31:0] instruction_pointer, // Current instruction address
    output logic privilege_select, // 1 privileged, 0 user
    output logic exception_hold_bit, // Block bit
    output logic bank_select, // General register bank
    output logic [3:0] interrupt_level_mask, // Level mask
    output logic saturate, // Saturation control
    output logic t_bit, // Condition bit
    output logic q_bit, // Quotient bit
    output logic m_bit, // Divisor sign bit
    output logic [31:0] global_base_pointer, // Addressing base
    output logic [31:0] multiply_acc_high, // Accumulator high
    output logic [31:0] multiply_acc_low, // Accumulator low
    output logic [31:0] return_address_holder, // Return address
    output logic float_bank_swap, // Float bank swap
    output logic move_pair_size, // 64-bit pair moves
    output logic double_precision, // Double precision
    output logic subnormal_flush, // Subnormals as zero
    output logic [1:0] rounding_select // Rounding mode
);
    ccsr_word_type core_state_word_reg, core_state_word_next;
    ccsr_word_type saved_state_copy_reg, saved_state_copy_next;
    ccsr_word_type saved_fetch_address_reg, saved_fetch_address_next;
    ccsr_word_type global_base_pointer_reg, global_base_pointer_next;
    ccsr_word_type trap_vector_base_reg, trap_vector_base_next;
    ccsr_word_type saved_stack_pointer_reg, saved_stack_pointer_next;
    ccsr_word_type break_handler_base_reg, break_handler_base_next;
    ccsr_word_type multiply_acc_high_reg, multiply_acc_high_next;
    ccsr_word_type multiply_acc_low_reg, multiply_acc_low_next;
    ccsr_word_type return_address_holder_reg, return_address_holder_next;
    ccsr_word_type instruction_pointer_reg, instruction_pointer_next;
    ccsr_word_type float_control_status_reg, float_control_status_next;
    ccsr_word_type trap_target_reg, trap_target_next;
    ccsr_word_type bus_rdata_reg, bus_rdata_next;
    logic core_operating_config_reg, core_operating_config_next;
    logic user_break_redirect_enable_reg, user_break_redirect_enable_next;
    logic bus_fault_reg, bus_fault_next;
    logic trap_taken_reg, trap_taken_next;
    ccsr_entry_type entry;
    logic priv;
    logic refused;

    ccsr_trap_if trap ();

    ccsr_irq_gate u_gate (
        .trap(trap)
    );

    ccsr_vec_sel u_vsel (
        .trap(trap)
    );

    // Registers that user mode may neither read nor write
    function automatic logic is_privileged(input logic [`CCSR_ADDR_W-1:0] a);
        is_privileged = (a == `CCSR_ADDR_STATE) || (a == `CCSR_ADDR_SAVED_STATE) ||
                        (a == `CCSR_ADDR_SAVED_FETCH) || (a == `CCSR_ADDR_VECTOR_BASE) ||
                        (a == `CCSR_ADDR_SAVED_STACK) || (a == `CCSR_ADDR_BREAK_BASE) ||
                        (a == `CCSR_ADDR_OP_CONFIG) || (a == `CCSR_ADDR_BREAK_CONFIG);
    endfunction

    // Only writable bits change; reserved bits keep their zero
    function automatic ccsr_word_type merge(input ccsr_word_type old_v, input ccsr_word_type new_v,
                                            input ccsr_word_type wmask);
        merge = (old_v & ~wmask) | (new_v & wmask);
    endfunction

    assign priv = core_state_word_reg[`CCSR_SR_MD];
    assign refused = (bus_wr || bus_rd) && !priv && is_privileged(bus_addr); // RQ23

    assign trap.mask = core_state_word_reg[`CCSR_SR_MASK_HI:`CCSR_SR_MASK_LO];
    assign trap.hold = core_state_word_reg[`CCSR_SR_BL];
    // A synchronous exception takes precedence over a pending interrupt
    assign trap.req = irq_req && !exc_req;
    assign trap.level = irq_level;
    assign trap.redirect = user_break_redirect_enable_reg;
    assign trap.brk = exc_req && exc_user_break;
    assign trap.vbase = trap_vector_base_reg;
    assign trap.dbase = break_handler_base_reg;
    assign trap.offset = exc_offset;

    assign irq_accept = trap.accept;

    always_comb
    begin
        if (exc_req)
            entry = CCSR_ENTRY_EXC;
        else if (trap.accept)
            entry = CCSR_ENTRY_IRQ;
        else
            entry = CCSR_ENTRY_NONE;
    end

    always_comb
    begin
        core_state_word_next = core_state_word_reg;
        saved_state_copy_next = saved_state_copy_reg;
        saved_fetch_address_next = saved_fetch_address_reg;
        global_base_pointer_next = global_base_pointer_reg;
        trap_vector_base_next = trap_vector_base_reg;
        saved_stack_pointer_next = saved_stack_pointer_reg;
        break_handler_base_next = break_handler_base_reg;
        multiply_acc_high_next = multiply_acc_high_reg;
        multiply_acc_low_next = multiply_acc_low_reg;
        return_address_holder_next = return_address_holder_reg;
        instruction_pointer_next = instruction_pointer_reg;
        float_control_status_next = float_control_status_reg;
        core_operating_config_next = core_operating_config_reg;
        user_break_redirect_enable_next = user_break_redirect_enable_reg;
        trap_target_next = trap_target_reg;
        bus_fault_next = refused;
        trap_taken_next = 1'b0;
        bus_rdata_next = `CCSR_WORD_ZERO;

        // Software writes first, hardware updates below override the same cycle
        if (bus_wr && !refused)
        begin
            unique case (bus_addr)
                `CCSR_ADDR_STATE:
                    core_state_word_next = merge(core_state_word_reg, bus_wdata,
                                                 `CCSR_SR_WMASK); // RQ3 RQ4
                `CCSR_ADDR_SAVED_STATE: saved_state_copy_next = bus_wdata;
                `CCSR_ADDR_SAVED_FETCH: saved_fetch_address_next = bus_wdata;
                `CCSR_ADDR_GLOBAL_BASE: global_base_pointer_next = bus_wdata;
                `CCSR_ADDR_VECTOR_BASE: trap_vector_base_next = bus_wdata;
                `CCSR_ADDR_SAVED_STACK: saved_stack_pointer_next = bus_wdata;
                `CCSR_ADDR_BREAK_BASE: break_handler_base_next = bus_wdata;
                `CCSR_ADDR_MAC_HIGH: multiply_acc_high_next = bus_wdata;
                `CCSR_ADDR_MAC_LOW: multiply_acc_low_next = bus_wdata;
                `CCSR_ADDR_RETURN: return_address_holder_next = bus_wdata;
                `CCSR_ADDR_FLOAT:
                    float_control_status_next = merge(float_control_status_reg, bus_wdata,
                                                      `CCSR_FP_WMASK); // RQ19
                `CCSR_ADDR_OP_CONFIG:
                    core_operating_config_next = bus_wdata[`CCSR_OPCFG_LEVEL_UPDATE];
                `CCSR_ADDR_BREAK_CONFIG:
                    user_break_redirect_enable_next = bus_wdata[`CCSR_BRKCFG_REDIRECT];
                default:
                begin
                end
            endcase
        end

        if (bus_rd && !refused)
        begin
            unique case (bus_addr)
                `CCSR_ADDR_STATE: bus_rdata_next = core_state_word_reg;
                `CCSR_ADDR_SAVED_STATE: bus_rdata_next = saved_state_copy_reg;
                `CCSR_ADDR_SAVED_FETCH: bus_rdata_next = saved_fetch_address_reg;
                `CCSR_ADDR_GLOBAL_BASE: bus_rdata_next = global_base_pointer_reg;
                `CCSR_ADDR_VECTOR_BASE: bus_rdata_next = trap_vector_base_reg;
                `CCSR_ADDR_SAVED_STACK: bus_rdata_next = saved_stack_pointer_reg;
                `CCSR_ADDR_BREAK_BASE: bus_rdata_next = break_handler_base_reg;
                `CCSR_ADDR_MAC_HIGH: bus_rdata_next = multiply_acc_high_reg;
                `CCSR_ADDR_MAC_LOW: bus_rdata_next = multiply_acc_low_reg;
                `CCSR_ADDR_RETURN: bus_rdata_next = return_address_holder_reg;
                `CCSR_ADDR_IPTR: bus_rdata_next = instruction_pointer_reg; // RQ14
                `CCSR_ADDR_FLOAT: bus_rdata_next = float_control_status_reg; // RQ19
                `CCSR_ADDR_OP_CONFIG:
                    bus_rdata_next = {31'h00000000, core_operating_config_reg};
                `CCSR_ADDR_BREAK_CONFIG:
                    bus_rdata_next = {31'h00000000, user_break_redirect_enable_reg};
                default: bus_rdata_next = `CCSR_WORD_ZERO;
            endcase
        end

        if (t_we)
            core_state_word_next[`CCSR_SR_T] = t_in; // RQ4
        if (div_we)
        begin
            core_state_word_next[`CCSR_SR_Q] = q_in; // RQ5
            core_state_word_next[`CCSR_SR_M] = m_in;
        end
        if (mac_we)
        begin
            multiply_acc_high_next = mac_hi_in; // RQ12
            multiply_acc_low_next = mac_lo_in;
        end

        // Flow of control: entry beats return, return beats call, call beats load
        if (pc_load)
            instruction_pointer_next = pc_value;
        if (call_take)
        begin
            return_address_holder_next = call_return; // RQ13
            instruction_pointer_next = call_target;
        end
        if (ret_take)
            instruction_pointer_next = return_address_holder_reg; // RQ13

        if (entry != CCSR_ENTRY_NONE)
        begin
            saved_state_copy_next = core_state_word_reg; // RQ6
            saved_fetch_address_next = exc_addr; // RQ7
            saved_stack_pointer_next = exc_r15; // RQ10
            core_state_word_next[`CCSR_SR_MD] = 1'b1; // RQ21
            core_state_word_next[`CCSR_SR_RB] = 1'b1;
            core_state_word_next[`CCSR_SR_BL] = 1'b1; // RQ20
            if (entry == CCSR_ENTRY_IRQ && core_operating_config_reg)
                core_state_word_next[`CCSR_SR_MASK_HI:`CCSR_SR_MASK_LO] = irq_level; // RQ2
            instruction_pointer_next = trap.target; // RQ9 RQ11
            trap_target_next = trap.target;
            trap_taken_next = 1'b1;
        end
    end

    // Words with no defined reset start at zero,
    // so a read never returns an unknown
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            core_state_word_reg <= `CCSR_SR_RESET; // RQ1 RQ3 RQ20 RQ21
            saved_state_copy_reg <= `CCSR_WORD_ZERO;
            saved_fetch_address_reg <= `CCSR_WORD_ZERO;
            global_base_pointer_reg <= `CCSR_WORD_ZERO;
            trap_vector_base_reg <= `CCSR_WORD_ZERO; // RQ9
            saved_stack_pointer_reg <= `CCSR_WORD_ZERO;
            break_handler_base_reg <= `CCSR_WORD_ZERO;
            multiply_acc_high_reg <= `CCSR_WORD_ZERO;
            multiply_acc_low_reg <= `CCSR_WORD_ZERO;
            return_address_holder_reg <= `CCSR_WORD_ZERO;
            instruction_pointer_reg <= `CCSR_IPTR_RESET; // RQ14
            float_control_status_reg <= `CCSR_FP_RESET; // RQ18 RQ22
            core_operating_config_reg <= 1'b0;
            user_break_redirect_enable_reg <= 1'b0;
            trap_target_reg <= `CCSR_WORD_ZERO;
            bus_rdata_reg <= `CCSR_WORD_ZERO;
            bus_fault_reg <= 1'b0;
            trap_taken_reg <= 1'b0;
        end
        else
        begin
            core_state_word_reg <= core_state_word_next;
            saved_state_copy_reg <= saved_state_copy_next;
            saved_fetch_address_reg <= saved_fetch_address_next;
            global_base_pointer_reg <= global_base_pointer_next;
            trap_vector_base_reg <= trap_vector_base_next;
            saved_stack_pointer_reg <= saved_stack_pointer_next;
            break_handler_base_reg <= break_handler_base_next;
            multiply_acc_high_reg <= multiply_acc_high_next;
            multiply_acc_low_reg <= multiply_acc_low_next;
            return_address_holder_reg <= return_address_holder_next;
            instruction_pointer_reg <= instruction_pointer_next;
            float_control_status_reg <= float_control_status_next;
            core_operating_config_reg <= core_operating_config_next;
            user_break_redirect_enable_reg <= user_break_redirect_enable_next;
            trap_target_reg <= trap_target_next;
            bus_rdata_reg <= bus_rdata_next;
            bus_fault_reg <= bus_fault_next;
            trap_taken_reg <= trap_taken_next;
        end
    end

    assign bus_rdata = bus_rdata_reg;
    assign bus_fault = bus_fault_reg;
    assign trap_taken = trap_taken_reg;
    assign trap_target = trap_target_reg;
    assign instruction_pointer = instruction_pointer_reg;
    assign privilege_select = core_state_word_reg[`CCSR_SR_MD]; // RQ21
    assign exception_hold_bit = core_state_word_reg[`CCSR_SR_BL];
    assign bank_select = core_state_word_reg[`CCSR_SR_RB];
    assign interrupt_level_mask = core_state_word_reg[`CCSR_SR_MASK_HI:`CCSR_SR_MASK_LO];
    assign saturate = core_state_word_reg[`CCSR_SR_S]; // RQ3
    assign t_bit = core_state_word_reg[`CCSR_SR_T];
    assign q_bit = core_state_word_reg[`CCSR_SR_Q]; // RQ5
    assign m_bit = core_state_word_reg[`CCSR_SR_M];
    assign global_base_pointer = global_base_pointer_reg; // RQ8
    assign multiply_acc_high = multiply_acc_high_reg; // RQ12
    assign multiply_acc_low = multiply_acc_low_reg;
    assign return_address_holder = return_address_holder_reg;
    assign float_bank_swap = float_control_status_reg[`CCSR_FP_FR]; // RQ15
    assign move_pair_size = float_control_status_reg[`CCSR_FP_SZ]; // RQ16
    // Graphics support instructions are undefined while this is high
    assign double_precision = float_control_status_reg[`CCSR_FP_PR]; // RQ17
    assign subnormal_flush = float_control_status_reg[`CCSR_FP_DN]; // RQ18
    assign rounding_select = float_control_status_reg[`CCSR_FP_RM_HI:`CCSR_FP_RM_LO]; // RQ22
endmodule
`default_nettype wire

// [bench/ccsr_regs_sva.sv]
// Concurrent checks on the ports of the core control register set
`timescale 1ns/1ps
`default_nettype none
module ccsr_regs_sva (
    input wire logic clk, rst, // Clock and reset
    input wire logic irq_req, irq_accept, exc_req, trap_taken, // Entry controls
    input wire logic [3:0] irq_level, interrupt_level_mask, // Levels
    input wire logic exception_hold_bit, privilege_select, // Mode bits
    input wire logic [31:0] trap_target, instruction_pointer, // Targets
    input wire logic call_take, ret_take, mac_we, t_we, t_in, t_bit, // Updates
    input wire logic [31:0] call_return, return_address_holder, // Return path
    input wire logic [31:0] mac_hi_in, multiply_acc_high // Accumulator
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Equal level is refused, so the comparison is strict
    a_irq_gate_level: assert property (irq_accept |-> irq_req && !exc_req && !exception_hold_bit
        && irq_level > interrupt_level_mask) else $error("interrupt accepted while masked");
    a_irq_gate_open: assert property (irq_req && !exc_req && !exception_hold_bit
        && irq_level > interrupt_level_mask |-> irq_accept) else $error("interrupt not accepted");
    a_entry_mode_set: assert property (exc_req || irq_accept |=> exception_hold_bit
        && privilege_select && trap_taken) else $error("entry left mode bits");
    a_entry_target: assert property (exc_req || irq_accept |=>
        instruction_pointer == trap_target) else $error("entry target not taken");
    a_reset_values: assert property ($fell(rst) |-> instruction_pointer == 32'ha0000000
        && interrupt_level_mask == 4'hf && exception_hold_bit) else $error("bad reset state");
    a_call_store: assert property (call_take |=> return_address_holder == $past(call_return))
        else $error("return address not stored");
    a_ret_jump: assert property (ret_take && !exc_req && !irq_accept |=>
        instruction_pointer == $past(return_address_holder)) else $error("bad return");
    a_mac_result: assert property (mac_we |=> multiply_acc_high == $past(mac_hi_in))
        else $error("accumulator not written");
    a_cond_write: assert property (t_we |=> t_bit == $past(t_in))
        else $error("condition bit not written");
endmodule
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the core control register set
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] bus_addr = 6'h00;
    logic bus_wr = 0, bus_rd = 0, irq_req = 0, exc_req = 0, exc_user_break = 0, pc_load = 0;
    logic call_take = 0, ret_take = 0, mac_we = 0, t_we = 0, t_in = 0, div_we = 0, q_in = 0, m_in = 0;
    logic [3:0] irq_level = 4'h0;
    logic [15:0] exc_offset = 16'h0000;
    logic [31:0] bus_wdata = 0, exc_addr = 0, exc_r15 = 0, pc_value = 0, call_return = 0;
    logic [31:0] call_target = 0, mac_hi_in = 0, mac_lo_in = 0, rv;
    wire logic [31:0] bus_rdata, trap_target, instruction_pointer, global_base_pointer;
    wire logic [31:0] multiply_acc_high, multiply_acc_low, return_address_holder;
    wire logic bus_fault, irq_accept, trap_taken, privilege_select, exception_hold_bit, bank_select;
    wire logic saturate, t_bit, q_bit, m_bit, float_bank_swap, move_pair_size, double_precision;
    wire logic subnormal_flush;
    wire logic [3:0] interrupt_level_mask;
    wire logic [1:0] rounding_select;
    logic rf;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    ccsr_regs uut (.*);
    initial forever #20 clk = ~clk;
    task automatic wrap_up;
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Whole run needs well under a thousand cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_mismatch++;
            wrap_up;
        end
    end
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        {bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
        @(posedge clk);
        bus_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [5:0] a);
        @(posedge clk);
        {bus_rd, bus_addr} <= {1'b1, a};
        @(posedge clk);
        bus_rd <= 1'b0;
        #1;
        {rv, rf} = {bus_rdata, bus_fault};
    endtask
    task automatic entry(input logic ub);
        @(posedge clk);
        {exc_req, exc_user_break} <= {1'b1, ub};
        @(posedge clk);
        exc_req <= 1'b0;
        #1;
    endtask
    task automatic t_reset;
        check(instruction_pointer, 32'ha0000000);
        rd(6'h00); check(rv, 32'h700000f0);
        rd(6'h2c); check(rv, 32'h00040001);
        rd(6'h10); check(rv, 32'h0);
        rd(6'h3c); check({rv, 31'h0, rf}, 64'h0);
    endtask
    task automatic t_float;
        wr(6'h2c, 32'hffffffff); check(32'({float_bank_swap, move_pair_size, double_precision, subnormal_flush}), 32'hf);
        rd(6'h2c); check(rv, 32'h003fffff);
        wr(6'h2c, 32'h0); check(32'({float_bank_swap, move_pair_size, double_precision, subnormal_flush, rounding_select}), 32'h0);
        wr(6'h0c, 32'h5a5aa5a5); check(global_base_pointer, 32'h5a5aa5a5);
    endtask
    task automatic t_irq;
        wr(6'h10, 32'h00001000);
        wr(6'h30, 32'h1);
        wr(6'h00, 32'h40000030);
        @(posedge clk);
        {irq_req, irq_level, exc_offset} <= {1'b1, 4'h3, 16'h0600};
        {exc_addr, exc_r15} <= {32'h00000abc, 32'h0000f00c};
        #1 check(32'(irq_accept), 32'h0);
        @(posedge clk);
        irq_level <= 4'h8;
        #1 check(32'(irq_accept), 32'h1);
        @(posedge clk);
        irq_level <= 4'hf;
        #1 check(32'({trap_taken, privilege_select, exception_hold_bit, irq_accept}), 32'he);
        check({interrupt_level_mask, instruction_pointer}, 36'h800001600);
        check(32'(bank_select), 32'h1);
        @(posedge clk);
        irq_req <= 1'b0;
        rd(6'h04); check(rv, 32'h40000030);
        rd(6'h08); check(rv, 32'h00000abc);
        rd(6'h14); check(rv, 32'h0000f00c);
    endtask
    task automatic t_brk_user;
        wr(6'h18, 32'h00003000);
        wr(6'h34, 32'h1);
        entry(1'b1); check({trap_target, instruction_pointer}, 64'h0000300000003000);
        wr(6'h34, 32'h0);
        entry(1'b1); check(instruction_pointer, 32'h00001600);
        wr(6'h00, 32'h000000f0);
        rd(6'h10); check({rv, 31'h0, rf}, 64'h1);
        wr(6'h10, 32'h0000dead);
        rd(6'h0c); check({rv, 31'h0, rf}, 64'h5a5aa5a500000000);
        entry(1'b0); check(32'(privilege_select), 32'h1);
        rd(6'h10); check(rv, 32'h00001000);
    endtask
    task automatic t_instr;
        @(posedge clk);
        {mac_we, t_we, t_in, div_we, q_in, m_in, call_take} <= 7'h7f;
        {mac_hi_in, mac_lo_in} <= {32'h12345678, 32'h9abcdef0};
        {call_return, call_target} <= {32'h00000104, 32'h00002000};
        @(posedge clk);
        {mac_we, t_we, t_in, div_we, q_in, call_take, ret_take} <= 7'h01;
        #1 check({multiply_acc_high, multiply_acc_low}, 64'h123456789abcdef0);
        check(32'({t_bit, q_bit, m_bit}), 32'h7);
        check({return_address_holder, instruction_pointer}, 64'h0000010400002000);
        @(posedge clk);
        {ret_take, pc_load, pc_value} <= {1'b0, 1'b1, 32'h00000200};
        #1 check(instruction_pointer, 32'h00000104);
        @(posedge clk);
        pc_load <= 1'b0;
        wr(6'h00, 32'h700000f2); check(32'({saturate, t_bit}), 32'h2);
        check(instruction_pointer, 32'h00000200);
    endtask
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_float;
        t_irq;
        t_brk_user;
        t_instr;
        wrap_up;
    end
endmodule
bind ccsr_regs ccsr_regs_sva chk (.*);
`default_nettype wire
